// ==== hw/iotl_pkg.sv ====
// Shared constants for the oscillator trim and low-frequency control block
package iotl_pkg;
  // ==========================================================================
  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ==========================================================================
  // Register indices as printed and byte addresses (index times four)
  localparam logic [ADDR_W-1:0] HF_TRIM_IDX = 12'h0b3;
  localparam logic [ADDR_W-1:0] LF_CTRL_IDX = 12'h0e3;
  localparam logic [ADDR_W-1:0] HF_TRIM_ADDR = 12'h2cc;
  localparam logic [ADDR_W-1:0] LF_CTRL_ADDR = 12'h38c;
  localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = 12'h000;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 12'h004;
  localparam logic [ADDR_W-1:0] CAP_CTRL_ADDR = 12'h008;
  localparam logic [ADDR_W-1:0] CAP_T2_ADDR = 12'h00c;
  localparam logic [ADDR_W-1:0] CAP_T3_ADDR = 12'h010;

  // ==========================================================================
  // Field positions of the low-frequency control register, and the high-frequency trim width
  localparam int LF_EN_BIT = 7;
  localparam int LF_RDY_BIT = 6;
  localparam int LF_TRIM_LSB = 2;
  localparam int LF_TRIM_W = 4;
  localparam int LF_SEL_LSB = 0;
  localparam int HF_TRIM_W = 7;

  // ==========================================================================
  // Divider select codes
  localparam logic [1:0] DIV_BY8 = 2'h0;
  localparam logic [1:0] DIV_BY4 = 2'h1;
  localparam logic [1:0] DIV_BY2 = 2'h2;
  localparam logic [1:0] DIV_BY1 = 2'h3;

  // ==========================================================================
  // Interrupt status bits, capture control bits
  localparam int IRQ_W = 3;
  localparam int IRQ_READY_BIT = 0;
  localparam int IRQ_CAP2_BIT = 1;
  localparam int IRQ_CAP3_BIT = 2;
  localparam int CAP2_EN_BIT = 0;
  localparam int CAP3_EN_BIT = 1;

  // ==========================================================================
  // Reset values and settling count
  localparam logic LF_EN_RST = 1'b0;
  localparam logic [1:0] LF_SEL_RST = 2'h0;
  localparam int SETTLE_W = 8;
  localparam logic [SETTLE_W-1:0] SETTLE_EDGES_DEF = 8'h10;
endpackage : iotl_pkg

// ==== hw/iotl_lf_div.sv ====
// Post-divider for the low-frequency oscillator output
`timescale 1ns/10ps
module iotl_lf_div
  import iotl_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic enable,
  input wire logic [1:0] divSel,
  // Synchronised oscillator level and its edges
  input wire logic oscLevel,
  input wire logic oscEdge,
  input wire logic oscRise,
  // Divided clock level
  output logic divClk
);
  import iotl_pkg::*;

  typedef struct packed {
    logic [1:0] actSel;
    logic [2:0] cnt;
    logic divClk;
  } iotl_div_state_t;

  iotl_div_state_t state_ff;
  iotl_div_state_t nxt_state;
  logic [2:0] cntInc;

  // ==========================================================================
  // Divider next state: a new selection is taken at an oscillator edge or while disabled
  always_comb begin
    nxt_state = state_ff;
    cntInc = state_ff.cnt + 3'h1;
    if (!enable) begin
      nxt_state.cnt = 3'h0; // [R12]
      nxt_state.divClk = 1'b0; // [R12]
      nxt_state.actSel = divSel;
    end else if (oscEdge) begin
      nxt_state.actSel = divSel; // [R12]
      if (oscRise) begin
        nxt_state.cnt = cntInc;
      end
      case (divSel)
        DIV_BY1: nxt_state.divClk = oscLevel; // [R8]
        DIV_BY2: nxt_state.divClk = nxt_state.cnt[0]; // [R8]
        DIV_BY4: nxt_state.divClk = nxt_state.cnt[1]; // [R8]
        default: nxt_state.divClk = nxt_state.cnt[2]; // [R8]
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign divClk = state_ff.divClk;
endmodule : iotl_lf_div

// ==== hw/iotl_osc_ctrl.sv ====
// Oscillator trim and low-frequency oscillator control with APB registers
//
// Behaviour
// R1: A 7-bit high-frequency period trim sits in bits 6:0, zero fastest, all ones slowest.
// R2: Bit 7 of the high-frequency trim register reads zero and ignores writes.
// R3: After reset the high-frequency trim takes the part's calibration value for 24.5 MHz.
// R4: Bit 7 of the low-frequency control enables the oscillator and resets to zero.
// R5: Read-only bit 6 reads one once the low-frequency oscillator has settled.
// R6: The ready flag is cleared only by reset or by a write that changes the divider select.
// R7: Bits 5:2 trim the low-frequency oscillator, zero fastest, reset value per part.
// R8: Bits 1:0 divide the oscillator by eight, four, two or one, resetting to divide by eight.
// R9: In capture mode timer 2 captures on falling and timer 3 on rising divided-clock edges.
// R10: Each capture copies that timer's count into its reload register pair.
// R11: Software measures the period from two successive captures and retunes the trim.
// R12: The divided clock stays low while disabled and takes a new divider at the next edge.
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
module iotl_osc_ctrl #(
  parameter logic [iotl_pkg::SETTLE_W-1:0] SETTLE_EDGES = iotl_pkg::SETTLE_EDGES_DEF
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [iotl_pkg::ADDR_W-1:0] paddr,
  input wire logic [iotl_pkg::DATA_W-1:0] pwdata,
  output logic [iotl_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Per-part calibration values
  input wire logic [iotl_pkg::HF_TRIM_W-1:0] hfTrimCal,
  input wire logic [iotl_pkg::LF_TRIM_W-1:0] lfTrimCal,
  // Oscillator controls
  output logic [iotl_pkg::HF_TRIM_W-1:0] hfTrim,
  output logic lfOscEnable,
  output logic [iotl_pkg::LF_TRIM_W-1:0] lfTrim,
  output logic lfOscReady,
  // Raw low-frequency oscillator output and divided clock
  input wire logic lfOscRaw,
  output logic lfDivClk,
  // Timer capture hook
  input wire logic [15:0] timer2Count,
  input wire logic [15:0] timer3Count,
  output logic [15:0] timer2Reload,
  output logic [15:0] timer3Reload,
  output logic timer2ReloadLoad,
  output logic timer3ReloadLoad,
  // Interrupt
  output logic irq
);
  import iotl_pkg::*;

  typedef struct packed {
    logic oscSync1;
    logic oscSync2;
    logic oscPrev;
    logic divPrev;
    logic loadPend;
    logic [HF_TRIM_W-1:0] hfTrim;
    logic lfEn;
    logic [LF_TRIM_W-1:0] lfTrim;
    logic [1:0] divSel;
    logic ready;
    logic [SETTLE_W-1:0] settle;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
    logic [1:0] capCtrl;
    logic [15:0] t2Rel;
    logic [15:0] t3Rel;
    logic t2Load;
    logic t3Load;
    logic [DATA_W-1:0] prdata;
  } iotl_state_t;

  iotl_state_t state_ff;
  iotl_state_t nxt_state;

  logic oscRise;
  logic oscFall;
  logic divRise;
  logic divFall;
  logic setupCyc;
  logic wrAcc;
  logic rdAcc;
  logic addrHit;
  logic selChange;
  logic t2Evt;
  logic t3Evt;
  logic [DATA_W-1:0] rdVal;
  logic [SETTLE_W-1:0] settleInc;

  // ==========================================================================
  // Edge detection; the first sync stage feeds only the second
  assign oscRise = state_ff.oscSync2 & ~state_ff.oscPrev;
  assign oscFall = ~state_ff.oscSync2 & state_ff.oscPrev;
  assign divRise = lfDivClk & ~state_ff.divPrev;
  assign divFall = ~lfDivClk & state_ff.divPrev;

  // Bus phases and decode
  assign setupCyc = psel & ~penable;
  assign wrAcc = psel & penable & pwrite & addrHit;
  assign rdAcc = psel & penable & ~pwrite & addrHit;
  assign selChange = wrAcc && (paddr == LF_CTRL_ADDR) &&
                     (pwdata[LF_SEL_LSB +: 2] != state_ff.divSel);
  // Capture ignores the drop forced by disabling, which is not an oscillator edge
  assign t2Evt = state_ff.capCtrl[CAP2_EN_BIT] & state_ff.lfEn & divFall; // [R9]
  assign t3Evt = state_ff.capCtrl[CAP3_EN_BIT] & state_ff.lfEn & divRise; // [R9]
  assign settleInc = state_ff.settle + 8'h01;

  // ==========================================================================
  // Address decode and read data
  always_comb begin
    addrHit = 1'b1;
    rdVal = '0;
    if (paddr == HF_TRIM_ADDR) begin
      rdVal = {25'h0, state_ff.hfTrim}; // [R2]
    end else if (paddr == LF_CTRL_ADDR) begin
      rdVal = {24'h0, state_ff.lfEn, state_ff.ready, state_ff.lfTrim, state_ff.divSel};
    end else if (paddr == IRQ_STAT_ADDR) begin
      rdVal = {29'h0, state_ff.irqStat};
    end else if (paddr == IRQ_MASK_ADDR) begin
      rdVal = {29'h0, state_ff.irqMask};
    end else if (paddr == CAP_CTRL_ADDR) begin
      rdVal = {30'h0, state_ff.capCtrl};
    end else if (paddr == CAP_T2_ADDR) begin
      rdVal = {16'h0, state_ff.t2Rel};
    end else if (paddr == CAP_T3_ADDR) begin
      rdVal = {16'h0, state_ff.t3Rel};
    end else begin
      addrHit = 1'b0;
    end
  end

  // ==========================================================================
  // Next state of the whole block
  always_comb begin
    nxt_state = state_ff;
    nxt_state.oscSync1 = lfOscRaw;
    nxt_state.oscSync2 = state_ff.oscSync1;
    nxt_state.oscPrev = state_ff.oscSync2;
    nxt_state.divPrev = lfDivClk;
    // Calibration values are caught one edge after reset release, never in reset
    if (state_ff.loadPend) begin
      nxt_state.loadPend = 1'b0;
      nxt_state.hfTrim = hfTrimCal; // [R3]
      nxt_state.lfTrim = lfTrimCal; // [R7]
    end
    // Read data is latched in setup so the access phase answers at once
    if (setupCyc) begin
      nxt_state.prdata = rdVal;
    end
    // Register writes at the completing access edge
    if (wrAcc) begin
      if (paddr == HF_TRIM_ADDR) begin
        nxt_state.hfTrim = pwdata[HF_TRIM_W-1:0]; // [R1] [R2]
      end else if (paddr == LF_CTRL_ADDR) begin
        nxt_state.lfEn = pwdata[LF_EN_BIT]; // [R4]
        nxt_state.lfTrim = pwdata[LF_TRIM_LSB +: LF_TRIM_W]; // [R7]
        nxt_state.divSel = pwdata[LF_SEL_LSB +: 2]; // [R8]
      end else if (paddr == IRQ_MASK_ADDR) begin
        nxt_state.irqMask = pwdata[IRQ_W-1:0];
      end else if (paddr == CAP_CTRL_ADDR) begin
        nxt_state.capCtrl = pwdata[1:0];
      end
    end
    // Settling: count rising oscillator edges while enabled; disabling keeps the flag
    if (!state_ff.lfEn) begin
      nxt_state.settle = '0;
    end else if (oscRise && !state_ff.ready) begin
      nxt_state.settle = settleInc;
      if (settleInc >= SETTLE_EDGES) begin
        nxt_state.ready = 1'b1; // [R5]
      end
    end
    // A divider change restarts settling and wins over a same-cycle set
    if (selChange) begin
      nxt_state.ready = 1'b0; // [R6]
      nxt_state.settle = '0;
    end
    // Timer captures
    nxt_state.t2Load = t2Evt;
    nxt_state.t3Load = t3Evt;
    if (t2Evt) begin
      nxt_state.t2Rel = timer2Count; // [R10]
    end
    if (t3Evt) begin
      nxt_state.t3Rel = timer3Count; // [R10]
    end
    // Status read clears only bits reported in setup, so later events survive
    if (rdAcc && paddr == IRQ_STAT_ADDR) begin
      nxt_state.irqStat = state_ff.irqStat & ~state_ff.prdata[IRQ_W-1:0];
    end
    if (nxt_state.ready && !state_ff.ready) begin
      nxt_state.irqStat[IRQ_READY_BIT] = 1'b1;
    end
    if (t2Evt) begin
      nxt_state.irqStat[IRQ_CAP2_BIT] = 1'b1;
    end
    if (t3Evt) begin
      nxt_state.irqStat[IRQ_CAP3_BIT] = 1'b1;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= '0;
      state_ff.loadPend <= 1'b1;
      state_ff.lfEn <= LF_EN_RST; // [R4]
      state_ff.divSel <= LF_SEL_RST; // [R8]
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================================
  // Divided low-frequency clock
  iotl_lf_div u_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(state_ff.lfEn),
    .divSel(state_ff.divSel),
    .oscLevel(state_ff.oscSync2),
    .oscEdge(oscRise | oscFall),
    .oscRise(oscRise),
    .divClk(lfDivClk)
  );

  // Outputs
  assign prdata = state_ff.prdata;
  assign pready = 1'b1; // Zero wait states
  assign pslverr = psel & penable & ~addrHit;
  assign hfTrim = state_ff.hfTrim;
  assign lfOscEnable = state_ff.lfEn;
  assign lfTrim = state_ff.lfTrim;
  assign lfOscReady = state_ff.ready;
  assign timer2Reload = state_ff.t2Rel;
  assign timer3Reload = state_ff.t3Rel;
  assign timer2ReloadLoad = state_ff.t2Load;
  assign timer3ReloadLoad = state_ff.t3Load;
  assign irq = |(state_ff.irqStat & state_ff.irqMask);

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_hf_write;
    wrAcc && paddr == HF_TRIM_ADDR |=> hfTrim == $past(pwdata[6:0]);
  endproperty
  a_hf_write: assert property (p_hf_write) else $error("trim write not applied"); // [R1]

  property p_hf_bit7;
    setupCyc && paddr == HF_TRIM_ADDR |=> prdata[31:7] == 25'h0;
  endproperty
  a_hf_bit7: assert property (p_hf_bit7) else $error("trim bit 7 not zero"); // [R2]

  property p_cal_load;
    !rst && state_ff.loadPend |=> hfTrim == $past(hfTrimCal) && lfTrim == $past(lfTrimCal);
  endproperty
  a_cal_load: assert property (p_cal_load) else $error("calibration not loaded"); // [R3]

  property p_enable;
    wrAcc && paddr == LF_CTRL_ADDR |=> lfOscEnable == $past(pwdata[7]);
  endproperty
  a_enable: assert property (p_enable) else $error("enable not applied"); // [R4]

  property p_ready_rise;
    $rose(lfOscReady) |-> $past(lfOscEnable) && $past(state_ff.settle) == SETTLE_EDGES - 8'h01;
  endproperty
  a_ready_rise: assert property (p_ready_rise) else $error("ready set early"); // [R5]

  property p_ready_fall;
    $fell(lfOscReady) |-> $past(selChange);
  endproperty
  a_ready_fall: assert property (p_ready_fall) else $error("ready cleared wrongly"); // [R6]

  property p_lf_fields;
    wrAcc && paddr == LF_CTRL_ADDR |=>
      lfTrim == $past(pwdata[5:2]) && state_ff.divSel == $past(pwdata[1:0]);
  endproperty
  a_lf_fields: assert property (p_lf_fields) else $error("trim or divider lost"); // [R7] [R8]

  property p_cap2;
    t2Evt |=> timer2ReloadLoad && timer2Reload == $past(timer2Count);
  endproperty
  a_cap2: assert property (p_cap2) else $error("timer 2 capture wrong"); // [R9] [R10]

  property p_cap3;
    $rose(lfDivClk) && state_ff.capCtrl[1] && lfOscEnable |=>
      timer3ReloadLoad && timer3Reload == $past(timer3Count);
  endproperty
  a_cap3: assert property (p_cap3) else $error("timer 3 capture wrong"); // [R9] [R10]

  property p_div_idle;
    !lfOscEnable [*2] |-> !lfDivClk;
  endproperty
  a_div_idle: assert property (p_div_idle) else $error("divided clock active"); // [R12]

  // Ready survives enable and trim writes; only a divider change drops it
  property p_ready_hold;
    lfOscReady && !selChange |=> lfOscReady;
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("ready lost"); // [R6]

  property p_ready_clr;
    selChange |=> !lfOscReady;
  endproperty
  a_ready_clr: assert property (p_ready_clr) else $error("ready kept on divider change"); // [R6]

  property p_rdy_read;
    setupCyc && paddr == LF_CTRL_ADDR |=>
      prdata[DATA_W-1:8] == 24'h0 && prdata[LF_RDY_BIT] == $past(lfOscReady);
  endproperty
  a_rdy_read: assert property (p_rdy_read) else $error("ready flag read wrong"); // [R5]

  // Capture pulses appear only in capture mode and last one cycle
  property p_cap2_off;
    !state_ff.capCtrl[CAP2_EN_BIT] |=> !timer2ReloadLoad;
  endproperty
  a_cap2_off: assert property (p_cap2_off) else $error("timer 2 capture outside mode"); // [R9]

  property p_cap3_off;
    !state_ff.capCtrl[CAP3_EN_BIT] |=> !timer3ReloadLoad;
  endproperty
  a_cap3_off: assert property (p_cap3_off) else $error("timer 3 capture outside mode"); // [R9]

  property p_reload_hold;
    timer2ReloadLoad |=> !timer2ReloadLoad && $stable(timer2Reload);
  endproperty
  a_reload_hold: assert property (p_reload_hold) else $error("reload pulse long"); // [R10]

  // Unmapped accesses are refused and read back zero, so software sees no stale data
  property p_unmapped;
    psel && penable && !addrHit |-> pslverr && prdata == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  c_ready: cover property ($rose(lfOscReady));
  c_cap2: cover property (timer2ReloadLoad);
  c_cap3: cover property (timer3ReloadLoad);
  c_irq: cover property ($rose(irq));
  c_sel: cover property (selChange);
endmodule : iotl_osc_ctrl

// ==== verification/internal_osc_trim_lf_control_tb_top.sv ====
// Self-checking bench for the oscillator trim and low-frequency control block
`timescale 1ns/10ps
module internal_osc_trim_lf_control_tb_top;
  import iotl_pkg::*;
  // ==========================================================================
  // Signals; raw oscillator half period in clock cycles
  localparam int HALF = 5;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, lfOscEnable, lfOscReady, lfDivClk, irq;
  logic [HF_TRIM_W-1:0] hfTrimCal = '0;
  logic [HF_TRIM_W-1:0] hfTrim;
  logic [LF_TRIM_W-1:0] lfTrimCal = '0;
  logic [LF_TRIM_W-1:0] lfTrim, trim;
  logic lfOscRaw = 1'b0;
  logic oscRun = 1'b0;
  logic divPrev = 1'b0;
  logic [15:0] timer2Count = '0;
  logic [15:0] timer3Count = '0;
  logic [15:0] timer2Reload, timer3Reload, t2Prev, t3Prev, t2Cap, t3Cap;
  logic timer2ReloadLoad, timer3ReloadLoad, slvErr;
  logic [31:0] seedDummy;
  logic [7:0] hfVals [4];
  int halfCnt = 0, cyc = 0, riseCyc = 0, divPer = 0, riseCnt = 0;
  int fail_count = 0, cmp_count = 0, cap2Cnt = 0, cap3Cnt = 0;

  // Small settling count keeps the ready wait short
  iotl_osc_ctrl #(.SETTLE_EDGES(8'h02)) DUT (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hfTrimCal(hfTrimCal), .lfTrimCal(lfTrimCal), .hfTrim(hfTrim),
    .lfOscEnable(lfOscEnable), .lfTrim(lfTrim), .lfOscReady(lfOscReady),
    .lfOscRaw(lfOscRaw), .lfDivClk(lfDivClk), .timer2Count(timer2Count),
    .timer3Count(timer3Count), .timer2Reload(timer2Reload), .timer3Reload(timer3Reload),
    .timer2ReloadLoad(timer2ReloadLoad), .timer3ReloadLoad(timer3ReloadLoad), .irq(irq));

  always #10 ref_clk = ~ref_clk;

  // ==========================================================================
  // Tasks and expectations
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // Request held until pready is seen high at an edge; no wait count assumed
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rdchk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    check_val(what, exp, q);
  endtask : rdchk

  function automatic int exp_period(input logic [1:0] s);
    return 2 * HALF * (s == DIV_BY8 ? 8 : s == DIV_BY4 ? 4 : s == DIV_BY2 ? 2 : 1);
  endfunction : exp_period

  // Select a new divider; ready must drop, then the period settles to the new ratio
  task automatic div_check(input logic [1:0] s);
    int r;
    wr(LF_CTRL_ADDR, {24'h0, 2'b10, trim, s});
    @(negedge ref_clk);
    check_val("ready after divider change", 32'h0, lfOscReady);
    r = riseCnt;
    wait (riseCnt >= r + 3);
    @(negedge ref_clk);
    check_val("divided period", exp_period(s), divPer);
  endtask : div_check

  // ==========================================================================
  // Free-running timers, raw oscillator, timeout and capture monitor
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    timer2Count <= timer2Count + 16'h1;
    timer3Count <= timer3Count + 16'h1;
    if (oscRun && halfCnt == HALF - 1) begin
      lfOscRaw <= ~lfOscRaw;
    end
    halfCnt <= (oscRun && halfCnt < HALF - 1) ? halfCnt + 1 : 0;
    if (cyc > 20000) begin
      fail_count++;
      final_report();
    end
  end

  // Captures are taken only at divide by two, so successive values differ by 20
  always @(posedge ref_clk) begin
    if (lfDivClk === 1'b1 && divPrev === 1'b0) begin
      divPer <= cyc - riseCyc;
      riseCyc <= cyc;
      riseCnt <= riseCnt + 1;
    end
    divPrev <= lfDivClk;
    if (timer2ReloadLoad === 1'b1) begin
      check_val("timer2 reload", t2Prev, timer2Reload);
      check_val("divclk at timer2 capture", 32'h0, lfDivClk);
      if (cap2Cnt > 0) check_val("timer2 delta", 4 * HALF, 16'(timer2Reload - t2Cap));
      t2Cap <= timer2Reload;
      cap2Cnt <= cap2Cnt + 1;
    end
    if (timer3ReloadLoad === 1'b1) begin
      check_val("timer3 reload", t3Prev, timer3Reload);
      check_val("divclk at timer3 capture", 32'h1, lfDivClk);
      if (cap3Cnt > 0) check_val("timer3 delta", 4 * HALF, 16'(timer3Reload - t3Cap));
      t3Cap <= timer3Reload;
      cap3Cnt <= cap3Cnt + 1;
    end
    t2Prev <= timer2Count;
    t3Prev <= timer3Count;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    seedDummy = $urandom(32'hd604);
    hfTrimCal = 7'($urandom);
    lfTrimCal = 4'($urandom);
    timer2Count = 16'($urandom) & 16'h3fff;
    timer3Count = 16'($urandom) & 16'h3fff;
    trim = 4'($urandom);
    hfVals = '{8'hff, 8'h80, 8'h00, 8'($urandom)};
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    check_val("hf trim after reset", hfTrimCal, hfTrim);
    rdchk("hf reg after reset", HF_TRIM_ADDR, {25'h0, hfTrimCal});
    check_val("slave error on mapped read", 32'h0, slvErr);
    rdchk("lf reg after reset", LF_CTRL_ADDR, {26'h0, lfTrimCal, 2'b00});
    foreach (hfVals[i]) begin
      wr(HF_TRIM_ADDR, {24'h0, hfVals[i]});
      rdchk("hf reg", HF_TRIM_ADDR, {25'h0, hfVals[i][6:0]});
      check_val("hf trim port", hfVals[i][6:0], hfTrim);
    end
    rdchk("unmapped read", 12'h100, 32'h0);
    check_val("slave error on unmapped read", 32'h1, slvErr);
    // Ready bit is read only, so writing it while disabled must not stick
    wr(LF_CTRL_ADDR, {24'h0, 2'b01, trim, DIV_BY1});
    rdchk("lf reg disabled", LF_CTRL_ADDR, {26'h0, trim, DIV_BY1});
    check_val("lf trim port", trim, lfTrim);
    wr(IRQ_MASK_ADDR, 32'h1);
    oscRun <= 1'b1;
    wr(LF_CTRL_ADDR, {24'h0, 2'b10, trim, DIV_BY1});
    @(negedge ref_clk);
    check_val("lf enable port", 32'h1, lfOscEnable);
    wait (lfOscReady === 1'b1);
    rdchk("lf reg ready", LF_CTRL_ADDR, {24'h0, 2'b11, trim, DIV_BY1});
    check_val("irq on ready", 32'h1, irq);
    rdchk("status ready", IRQ_STAT_ADDR, 32'h1);
    @(negedge ref_clk);
    check_val("irq cleared", 32'h0, irq);
    // Trim change and disable keep the ready flag; only a divider change drops it
    trim = ~trim;
    wr(LF_CTRL_ADDR, {24'h0, 2'b10, trim, DIV_BY1});
    rdchk("ready kept on trim", LF_CTRL_ADDR, {24'h0, 2'b11, trim, DIV_BY1});
    wr(LF_CTRL_ADDR, {24'h0, 2'b00, trim, DIV_BY1});
    rdchk("ready kept on disable", LF_CTRL_ADDR, {24'h0, 2'b01, trim, DIV_BY1});
    repeat (20) begin
      @(negedge ref_clk);
      check_val("divclk while disabled", 32'h0, lfDivClk);
    end
    div_check(DIV_BY8);
    div_check(DIV_BY4);
    div_check(DIV_BY1);
    div_check(DIV_BY2);
    wr(IRQ_MASK_ADDR, 32'h6);
    wr(CAP_CTRL_ADDR, 32'h3);
    wait (cap2Cnt >= 3 && cap3Cnt >= 3);
    wr(CAP_CTRL_ADDR, 32'h0);
    check_val("irq on capture", 32'h1, irq);
    wr(IRQ_MASK_ADDR, 32'h0);
    @(negedge ref_clk);
    check_val("irq masked", 32'h0, irq);
    rdchk("status all", IRQ_STAT_ADDR, 32'h7);
    rdchk("status cleared", IRQ_STAT_ADDR, 32'h0);
    wr(CAP_T2_ADDR, 32'hffff);
    rdchk("timer2 capture reg", CAP_T2_ADDR, {16'h0, t2Cap});
    rdchk("timer3 capture reg", CAP_T3_ADDR, {16'h0, t3Cap});
    final_report();
  end
endmodule : internal_osc_trim_lf_control_tb_top
